/* inc/spw_pkg.sv */
// spw_pkg: constants for the sine pwm carrier generator and output stage
// assumes a 100 MHz system clock; counting runs at half the oscillator rate
package spw_pkg;
  localparam int unsigned CLK_MHZ = 100;
  // oscillator and counting clock, in kHz
  localparam int unsigned OSC_KHZ = 25000;
  localparam int unsigned CNT_KHZ = OSC_KHZ / 2;
  // strobe divider from the 100 MHz system clock down to the count rate
  localparam int unsigned DIV_RATIO = (CLK_MHZ * 1000) / CNT_KHZ;
  localparam logic [3:0] DIV_LAST = 4'(DIV_RATIO - 1);
  // carrier period counters
  localparam logic [7:0] PERIOD_LAST = 8'hf9;
  // ramp-slope counter: carrier periods per duty ramp, minus one
  localparam logic [15:0] RAMP_LAST = 16'h0018;
  // phase offset starts at zero, moves ten counts per ramp step
  localparam logic [7:0] PHASE_INIT = 8'h00;
  localparam logic [7:0] PHASE_STEP = 8'h0a;
  // ramp steps per half triangle of the duty sweep
  localparam logic [4:0] STEPS_LAST = 5'h18;
  typedef enum logic {SPW_RISE, SPW_FALL} spw_dir_t;
endpackage

/* verilog/spw_out_stage.sv */
// spw_out_stage: modulated output and its complement toward the bridge leg
// assumes the comparator result arrives synchronous to clk_i
`timescale 1ns/1ns
`default_nettype none
module spw_out_stage (
  input wire logic clk_i,      // system clock
  input wire logic resetn_i,   // async reset, active low
  input wire logic ce_i,       // clock enable
  input wire logic cmp_i,      // comparator result
  output logic pwm_hi_o,       // modulated gate drive
  output logic pwm_lo_o        // complementary gate drive
);
  logic out_reg;
  wire logic complement_lookup;
  assign complement_lookup = ~out_reg;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      out_reg <= 1'b0;
    end else if (ce_i) begin
      out_reg <= cmp_i;
    end
  end
  assign pwm_hi_o = out_reg;
  assign pwm_lo_o = complement_lookup;

  a_pair_complement: assert property (@(posedge clk_i) disable iff (!resetn_i)
    pwm_hi_o != pwm_lo_o) else $error("gate pair not complementary");
endmodule // spw_out_stage
`default_nettype wire

/* verilog/spw_core.sv */
// spw_core: triangle-duty carrier pulse train, sine comparator, gate drive
// assumes sine_above_i is a synchronous digital comparator result
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - counters tick at 12.5 MHz rate
// - period counters run 250 cycles, 50 kHz
// - pulse width follows counter phase offset
// - ramp counter terminal 24, 500 us ramp
// - full duty sweep takes 1 ms
// - other output rates via counter values
// - output is plain compare, no hysteresis
// - complement made by single-input inverter
// - gate signals on two separate pins
// - output high while sine above carrier
module spw_core
  import spw_pkg::*;
(
  input wire logic clk_i,         // system clock, 100 MHz
  input wire logic resetn_i,      // async reset, active low
  input wire logic ce_i,          // clock enable, freezes all state
  input wire logic sine_above_i,  // comparator: sine above carrier
  output logic carrier_pwm_o,     // pulse train to external rc filter
  output logic pwm_hi_o,          // modulated gate drive
  output logic pwm_lo_o,          // complementary gate drive
  output logic sweep_dir_o        // high while duty falls
);
  logic [3:0] div_reg;
  logic [7:0] carrier_period_counter_a;
  logic [7:0] carrier_period_counter_b;
  logic [15:0] ramp_slope_counter;
  logic [7:0] phase_reg;
  logic pwm_reg;
  spw_dir_t dir_reg;

  // one strobe per counting clock period keeps a single clock domain
  wire logic tick = ce_i && (div_reg == DIV_LAST);
  wire logic a_wrap = carrier_period_counter_a == PERIOD_LAST;
  wire logic b_wrap = carrier_period_counter_b == PERIOD_LAST;
  // the ramp length times the carrier period sets the triangle period; another output
  // rate needs a different RAMP_LAST with RAMP_LAST * PHASE_STEP kept below PERIOD_LAST
  wire logic ramp_end = a_wrap && (ramp_slope_counter == RAMP_LAST);
  wire logic period_end = tick && a_wrap;
  wire logic ramp_flip = period_end && ramp_end;
  wire logic [7:0] phase_up = phase_reg + PHASE_STEP;
  wire logic [7:0] phase_down = phase_reg - PHASE_STEP;
  wire logic [7:0] phase_slope = (dir_reg == SPW_RISE) ? phase_up : phase_down;
  // held on the turn so the peak never passes 24 steps and b_start
  // cannot wrap below zero
  wire logic [7:0] phase_next = ramp_end ? phase_reg : phase_slope;
  // b trails a by phase_reg + 1 counts; the pulse spans that gap
  wire logic [7:0] b_start = PERIOD_LAST - phase_reg;
  wire logic pwm_next = a_wrap ? 1'b1 : (b_wrap ? 1'b0 : pwm_reg);

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      div_reg <= 4'h0;
    end else if (ce_i) begin
      div_reg <= (div_reg == DIV_LAST) ? 4'h0 : div_reg + 4'h1;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      carrier_period_counter_a <= 8'h00;
      carrier_period_counter_b <= 8'h00;
    end else if (tick) begin
      carrier_period_counter_a <= a_wrap ? 8'h00 :
        carrier_period_counter_a + 8'h01;
      // b reloads from b_start at each wrap of a so the offset tracks phase_reg
      carrier_period_counter_b <= a_wrap ? b_start :
        (b_wrap ? 8'h00 : carrier_period_counter_b + 8'h01);
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ramp_slope_counter <= 16'h0000;
    end else if (tick && a_wrap) begin
      ramp_slope_counter <= (ramp_slope_counter == RAMP_LAST) ? 16'h0000 :
        ramp_slope_counter + 16'h0001;
    end
  end

  // one ramp rises and the next falls: 25 + 25 carrier periods make the
  // whole sweep 1 ms; the phase moves once per carrier period except on the turn
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      phase_reg <= PHASE_INIT;
      dir_reg <= SPW_RISE;
    end else if (period_end) begin
      phase_reg <= phase_next;
      if (ramp_end) begin
        case (dir_reg)
          SPW_RISE: dir_reg <= SPW_FALL;
          SPW_FALL: dir_reg <= SPW_RISE;
          default: dir_reg <= SPW_RISE;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pwm_reg <= 1'b0;
    end else if (tick) begin
      pwm_reg <= pwm_next;
    end
  end

  assign carrier_pwm_o = pwm_reg;
  assign sweep_dir_o = (dir_reg == SPW_FALL);

  // direct compare result, no filtering or hysteresis added here
  spw_out_stage u_out (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .ce_i(ce_i),
    .cmp_i(sine_above_i),
    .pwm_hi_o(pwm_hi_o),
    .pwm_lo_o(pwm_lo_o)
  );

  a_period_wrap: assert property (@(posedge clk_i) disable iff (!resetn_i)
    tick && a_wrap |=> carrier_period_counter_a == 8'h00)
    else $error("period counter did not wrap at 249");
  a_period_count: assert property (@(posedge clk_i) disable iff (!resetn_i)
    carrier_period_counter_a <= PERIOD_LAST)
    else $error("period counter beyond terminal");
  a_ramp_bound: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ramp_slope_counter <= RAMP_LAST)
    else $error("ramp counter beyond 24");
  a_tick_spacing: assert property (@(posedge clk_i) disable iff (!resetn_i)
    tick |=> !tick) else $error("count strobe too dense");
  sequence s_rise_end;
    ramp_flip && dir_reg == SPW_RISE;
  endsequence
  sequence s_fall_end;
    ramp_flip && dir_reg == SPW_FALL;
  endsequence
  sequence s_rise_step;
    period_end && !ramp_end && dir_reg == SPW_RISE;
  endsequence
  sequence s_fall_step;
    period_end && !ramp_end && dir_reg == SPW_FALL;
  endsequence
  // eight enabled edges after a strobe bring the next one
  sequence s_tick_run;
    tick ##1 ce_i [*8];
  endsequence
  a_tick_period: assert property (@(posedge clk_i) disable iff (!resetn_i)
    s_tick_run |-> tick)
    else $error("count strobe not every eighth edge");
  a_div_bound: assert property (@(posedge clk_i) disable iff (!resetn_i)
    div_reg <= DIV_LAST)
    else $error("divider beyond terminal");
  a_ramp_wrap: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ramp_flip |=> ramp_slope_counter == 16'h0000)
    else $error("ramp counter did not wrap at 24");
  a_dir_return: assert property (@(posedge clk_i) disable iff (!resetn_i)
    s_fall_end |=> dir_reg == SPW_RISE)
    else $error("sweep did not turn back up");
  a_phase_rise: assert property (@(posedge clk_i) disable iff (!resetn_i)
    s_rise_step |=> phase_reg == $past(phase_reg) + PHASE_STEP)
    else $error("phase did not step up");
  a_phase_fall: assert property (@(posedge clk_i) disable iff (!resetn_i)
    s_fall_step |=> phase_reg == $past(phase_reg) - PHASE_STEP)
    else $error("phase did not step down");
  a_turn_hold: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ramp_flip |=> $stable(phase_reg))
    else $error("phase moved on the turn");
  a_phase_below: assert property (@(posedge clk_i) disable iff (!resetn_i)
    phase_reg < PERIOD_LAST)
    else $error("phase offset beyond period");
  a_b_reload: assert property (@(posedge clk_i) disable iff (!resetn_i)
    period_end |=> carrier_period_counter_b == PERIOD_LAST - $past(phase_reg))
    else $error("offset counter not reloaded");
  a_pulse_end: assert property (@(posedge clk_i) disable iff (!resetn_i)
    tick && b_wrap && !a_wrap |=> !carrier_pwm_o)
    else $error("pulse not ended at offset");
  a_ce_freeze: assert property (@(posedge clk_i) disable iff (!resetn_i)
    resetn_i && !ce_i |=> $stable(div_reg) && $stable(phase_reg))
    else $error("state moved with enable low");
  a_ce_counts: assert property (@(posedge clk_i) disable iff (!resetn_i)
    resetn_i && !ce_i |=> $stable(carrier_period_counter_a)
      && $stable(ramp_slope_counter))
    else $error("counters moved with enable low");
  a_gate_freeze: assert property (@(posedge clk_i) disable iff (!resetn_i)
    resetn_i && !ce_i |=> $stable(pwm_hi_o))
    else $error("gate drive moved with enable low");
  a_dir_reverse: assert property (@(posedge clk_i) disable iff (!resetn_i)
    s_rise_end |=> dir_reg == SPW_FALL)
    else $error("sweep did not reverse");
  a_pulse_start: assert property (@(posedge clk_i) disable iff (!resetn_i)
    tick && a_wrap |=> carrier_pwm_o)
    else $error("pulse not started at period start");
  a_out_follow: assert property (@(posedge clk_i) disable iff (!resetn_i)
    resetn_i && ce_i |=> pwm_hi_o == $past(sine_above_i))
    else $error("gate output does not follow compare");
  a_phase_hold: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !period_end |=> $stable(phase_reg))
    else $error("phase moved outside a ramp step");
endmodule // spw_core
`default_nettype wire

/* test/spw_bridge_model.sv */
// spw_bridge_model: gate inputs of one bridge leg
// assumes both gate drives come straight from the output stage pins
`timescale 1ns/1ns
`default_nettype none
module spw_bridge_model (
  input wire logic clk_i,  // system clock
  input wire logic hi_i,   // high-side gate
  input wire logic lo_i,   // low-side gate
  output logic leg_fault_o // gates seen equal
);
  // latched, so one bad cycle is not lost before the bench looks
  initial leg_fault_o = 1'b0;
  always @(negedge clk_i) begin
    if (hi_i === lo_i) leg_fault_o <= 1'b1;
  end
endmodule // spw_bridge_model
`default_nettype wire

/* test/spw_carrier_and_output_stage_bench.sv */
// spw_carrier_and_output_stage_bench: random gate drive, carrier timing
// assumes spw_core runs with no parameters on a 100 MHz clock
`timescale 1ns/1ns
`default_nettype none
module spw_carrier_and_output_stage_bench;
  import spw_pkg::*;
  logic clk_i, resetn_i, ce_i, sine_above_i, rand_ce, chk_on, exp_hi;
  logic carrier_pwm_o, pwm_hi_o, pwm_lo_o, sweep_dir_o, leg_fault;
  int failures, total_checks, h, l, w1;
  spw_core dut (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i),
    .sine_above_i(sine_above_i), .carrier_pwm_o(carrier_pwm_o),
    .pwm_hi_o(pwm_hi_o), .pwm_lo_o(pwm_lo_o), .sweep_dir_o(sweep_dir_o));
  spw_bridge_model leg (.clk_i(clk_i), .hi_i(pwm_hi_o), .lo_i(pwm_lo_o),
    .leg_fault_o(leg_fault));
  function automatic int period_clocks();
    return (int'(PERIOD_LAST) + 1) * int'(DIV_RATIO);
  endfunction
  // phase of the pulse launched at carrier period m: up one ramp, down next
  function automatic int exp_phase(int m);
    int r;
    int q;
    r = int'(RAMP_LAST) + 1;
    q = m % (2 * r);
    return ((q < r) ? q : (2 * r - 1 - q)) * int'(PHASE_STEP);
  endfunction
  // sweep falls after period ends r-1 .. 2r-2 of each triangle
  function automatic logic exp_fall(int j);
    int r;
    int q;
    r = int'(RAMP_LAST) + 1;
    q = j % (2 * r);
    return (q >= r - 1) && (q <= 2 * r - 2);
  endfunction
  task automatic complete_run();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic check_bit(logic got, logic exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t bit got %b exp %b", $time, got, exp);
    end
  endtask
  task automatic check_int(int got, int exp);
    total_checks++;
    if (got != exp) begin
      failures++;
      $display("[FAIL] %0t count got %0d exp %0d", $time, got, exp);
    end
  endtask
  // one period from a rising edge of the pulse train to the next
  task automatic measure(output int high, output int len);
    int n;
    high = 0;
    len = 0;
    n = 0;
    while (carrier_pwm_o !== 1'b1 && n < 5000) begin
      @(negedge clk_i);
      n++;
    end
    while (carrier_pwm_o === 1'b1 && n < 5000) begin
      @(negedge clk_i);
      high++;
      n++;
    end
    while (carrier_pwm_o !== 1'b1 && n < 5000) begin
      @(negedge clk_i);
      len++;
      n++;
    end
    len += high;
    if (n >= 5000) begin
      failures++;
      complete_run();
    end
  endtask
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // reference of the gate drive: one sample per enabled edge
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) exp_hi <= 1'b0;
    else if (ce_i) exp_hi <= sine_above_i;
  end
  always @(negedge clk_i) begin
    if (chk_on) begin
      check_bit(pwm_hi_o, exp_hi);
      check_bit(pwm_lo_o, ~exp_hi);
    end
  end
  initial begin
    resetn_i = 1'b0;
    ce_i = 1'b1;
    sine_above_i = 1'b0;
    rand_ce = 1'b0;
    chk_on = 1'b0;
    failures = 0;
    total_checks = 0;
    void'($urandom(32'h8542));
    repeat (16) @(posedge clk_i);
    chk_on = 1'b1;
    check_bit(carrier_pwm_o, 1'b0);
    fork
      forever begin
        @(posedge clk_i);
        sine_above_i <= 1'($urandom);
        ce_i <= rand_ce ? 1'($urandom) : 1'b1;
      end
    join_none
    resetn_i <= 1'b1;
    for (int k = 0; k <= 35; k++) begin
      measure(h, l);
      check_int(l, period_clocks());
      check_int(h, (exp_phase(k) + 1) * int'(DIV_RATIO));
      check_bit(sweep_dir_o, exp_fall(k + 1));
      if (k == 0) w1 = h;
      if (k == 1) check_int(h - w1, int'(PHASE_STEP) * int'(DIV_RATIO));
    end
    $display("test carrier done");
    rand_ce = 1'b1;
    repeat (3000) @(posedge clk_i);
    resetn_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    check_bit(carrier_pwm_o, 1'b0);
    check_bit(sweep_dir_o, 1'b0);
    resetn_i <= 1'b1;
    repeat (500) @(posedge clk_i);
    check_bit(leg_fault, 1'b0);
    $display("test random drive done");
    complete_run();
  end
endmodule // spw_carrier_and_output_stage_bench
`default_nettype wire
